// file: adsc_defs.svh
// Purpose: Constants for the converter sequencer and alarm filter configuration block
// Assumes: 50 MHz mclk; byte-wide register port fed by the serial interface decoder
// Notes:   Offsets, field positions, reset values and sample timing counts
`ifndef ADSC_DEFS_SVH
`define ADSC_DEFS_SVH

// Register offsets
`define ADSC_ADDR_UPDATE      8'h0F
`define ADSC_ADDR_CONV_CFG    8'h10
`define ADSC_ADDR_ALARM_CFG   8'h11

// Reset values, reserved bits zero
`define ADSC_CONV_CFG_RESET   8'h00
`define ADSC_ALARM_CFG_RESET  8'h70

// Field positions
`define ADSC_UPDATE_XFER_BIT  4
`define ADSC_MODE_BIT         7
`define ADSC_RATE_HI          6
`define ADSC_RATE_LO          5
`define ADSC_REFBUF_BIT       4
`define ADSC_CHF_HI           7
`define ADSC_CHF_LO           5
`define ADSC_TMF_HI           4
`define ADSC_TMF_LO           3

// Channels: 21 inputs plus the temperature sensor
`define ADSC_NUM_CH           22
`define ADSC_TEMP_CH          21
`define ADSC_BIPOLAR_MASK     22'h00FFFF

// Sample times in ns and derived cycle counts, rounded up
`define ADSC_CLK_PERIOD_NS    20
`define ADSC_T_SAMPLE_0_NS    11500
`define ADSC_T_SAMPLE_1_NS    23000
`define ADSC_T_SAMPLE_2_NS    34500
`define ADSC_T_SAMPLE_3_NS    69000
`define ADSC_CYC(ns)          ((ns + `ADSC_CLK_PERIOD_NS - 1) / `ADSC_CLK_PERIOD_NS)

`endif

// file: adsc_pkg.sv
// Purpose: Types and decode functions for the sequencer configuration block
// Assumes: adsc_defs.svh on the include path
// Notes:   Decoders are used by the top module; the sample window decoder also by its assertions
`include "adsc_defs.svh"

package adsc_pkg;

  typedef enum logic [0:0] {SEQ_IDLE, SEQ_SAMPLE} adsc_seq_type;

  typedef struct packed {
    adsc_seq_type                       seq;
    logic                               active;
    logic [4:0]                         chan;
    logic [11:0]                        cnt;
    logic                               done;
    logic [7:0]                         conv_cfg;
    logic [7:0]                         alarm_cfg;
    logic [7:0]                         rdata;
    logic [`ADSC_NUM_CH-1:0][11:0]      latest;
    logic [`ADSC_NUM_CH-1:0][11:0]      shown;
    logic [11:0]                        rd_data;
  } adsc_state_type;

  typedef struct packed {
    logic [8:0] cnt;
    logic       alarm;
  } adsc_filt_type;

  // Channel filter code to run length
  function automatic logic [8:0] adsc_chan_need(input logic [2:0] code);
    unique case (code)
      3'h0: adsc_chan_need = 9'h001;
      3'h1: adsc_chan_need = 9'h004;
      3'h2: adsc_chan_need = 9'h008;
      3'h3: adsc_chan_need = 9'h010;
      3'h4: adsc_chan_need = 9'h020;
      3'h5: adsc_chan_need = 9'h040;
      3'h6: adsc_chan_need = 9'h080;
      3'h7: adsc_chan_need = 9'h100;
    endcase
  endfunction : adsc_chan_need

  // Temperature filter code to run length
  function automatic logic [8:0] adsc_temp_need(input logic [1:0] code);
    unique case (code)
      2'h0: adsc_temp_need = 9'h001;
      2'h1: adsc_temp_need = 9'h002;
      2'h2: adsc_temp_need = 9'h004;
      2'h3: adsc_temp_need = 9'h008;
    endcase
  endfunction : adsc_temp_need

  // Sample window in cycles; bipolar inputs never go below the third step
  function automatic logic [11:0] adsc_sample_cycles(input logic [1:0] rate, input logic bipolar);
    logic [1:0] eff;
    eff = (bipolar && rate != 2'h3) ? 2'h2 : rate;
    unique case (eff)
      2'h0: adsc_sample_cycles = 12'(`ADSC_CYC(`ADSC_T_SAMPLE_0_NS));
      2'h1: adsc_sample_cycles = 12'(`ADSC_CYC(`ADSC_T_SAMPLE_1_NS));
      2'h2: adsc_sample_cycles = 12'(`ADSC_CYC(`ADSC_T_SAMPLE_2_NS));
      2'h3: adsc_sample_cycles = 12'(`ADSC_CYC(`ADSC_T_SAMPLE_3_NS));
    endcase
  endfunction : adsc_sample_cycles

endpackage : adsc_pkg

// file: adsc_alarm_filter.sv
// Purpose: Consecutive out-of-range qualification for one channel
// Assumes: need is at least 1 and at most 256
// Notes:   Counter saturates at need so a lowered threshold acts at once
`timescale 1ns/1ns

module adsc_alarm_filter
  import adsc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       sample_valid,
  input  wire logic       out_of_range,
  input  wire logic [8:0] need,
  output logic            alarm_r
);

  adsc_filt_type s_r;
  adsc_filt_type s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Run counter
  always_comb begin
    s_nxt = s_r;
    if (sample_valid) begin
      if (out_of_range) begin
        if (s_r.cnt + 9'h001 >= need) begin
          s_nxt.cnt   = need;
          s_nxt.alarm = 1'b1;
        end else begin
          s_nxt.cnt = s_r.cnt + 9'h001;
        end
      end else begin
        s_nxt.cnt   = 9'h000;
        s_nxt.alarm = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign alarm_r = s_r.alarm;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_run_len;
    @(posedge mclk) disable iff (rst)
      $rose(s_r.alarm) |-> $past(s_r.cnt) + 9'h001 >= $past(need) && $past(out_of_range);
  endproperty
  a_run_len: assert property (p_run_len) else $error("alarm set before run length reached");

  property p_break_clears;
    @(posedge mclk) disable iff (rst)
      (sample_valid && !out_of_range) |=> (s_r.cnt == 9'h000 && !s_r.alarm);
  endproperty
  a_break_clears: assert property (p_break_clears) else $error("in-range sample left count");

endmodule : adsc_alarm_filter

// file: adsc_top.sv
// Purpose: Conversion sequencer, sample timing, result transfer and alarm filter setup
// Assumes: Register port driven by the serial decoder; converter returns tagged results
// Notes:   Channel enables come from the mux enable registers outside this block
`timescale 1ns/1ns
`include "adsc_defs.svh"

module adsc_top
  import adsc_pkg::*;
#(
  parameter logic [`ADSC_NUM_CH-1:0] BIPOLAR_MASK = `ADSC_BIPOLAR_MASK
)
(
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic                    reg_wr_en,
  input  wire logic                    reg_rd_en,
  input  wire logic [7:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  output logic      [7:0]              reg_rdata_r,
  input  wire logic [`ADSC_NUM_CH-1:0] chan_enable,
  input  wire logic                    conv_trigger,
  output logic      [4:0]              mux_select_r,
  output logic                         sample_active_r,
  output logic                         sample_done_r,
  output logic                         reference_buffer_enable_r,
  input  wire logic                    conv_result_valid,
  input  wire logic [4:0]              conv_result_chan,
  input  wire logic [11:0]             conv_result_data,
  input  wire logic                    conv_result_out_of_range,
  input  wire logic [4:0]              result_rd_chan,
  output logic      [11:0]             result_rd_data_r,
  output logic      [`ADSC_NUM_CH-1:0] alarm_qualified_r
);

  adsc_state_type s_r;
  adsc_state_type s_nxt;

  logic       conversion_mode_select;
  logic [1:0] sample_time_select;
  logic [2:0] channel_alarm_filter_count;
  logic [1:0] temperature_alarm_filter_count;
  logic       update_xfer;
  logic       any_enabled;
  logic [5:0] first_hit;
  logic [5:0] next_hit;

  assign conversion_mode_select         = s_r.conv_cfg[`ADSC_MODE_BIT];
  assign sample_time_select             = s_r.conv_cfg[`ADSC_RATE_HI:`ADSC_RATE_LO];
  assign channel_alarm_filter_count     = s_r.alarm_cfg[`ADSC_CHF_HI:`ADSC_CHF_LO];
  assign temperature_alarm_filter_count = s_r.alarm_cfg[`ADSC_TMF_HI:`ADSC_TMF_LO];
  assign update_xfer = reg_wr_en && reg_addr == `ADSC_ADDR_UPDATE && reg_wdata[`ADSC_UPDATE_XFER_BIT];
  assign any_enabled = |chan_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Lowest enabled channel at or above start; bit 5 flags a hit
  function automatic logic [5:0] find_from(input logic [`ADSC_NUM_CH-1:0] mask,
                                           input logic [5:0] start);
    find_from = 6'h00;
    for (int i = `ADSC_NUM_CH - 1; i >= 0; i--) begin
      if (mask[i] && 6'(i) >= start) begin
        find_from = {1'b1, 5'(i)};
      end
    end
  endfunction : find_from

  // Sample window reload for a channel
  function automatic logic [11:0] reload(input logic [1:0] rate, input logic [4:0] ch);
    reload = adsc_sample_cycles(rate, BIPOLAR_MASK[ch]) - 12'h001;
  endfunction : reload

  assign first_hit = find_from(chan_enable, 6'h00);
  assign next_hit  = find_from(chan_enable, {1'b0, s_r.chan} + 6'h01);

  ////////////////////////////////////////////////////////////////////////////
  // Next state: registers, result transfer, sequencer
  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;

    // Register writes; reserved bits store as written
    if (reg_wr_en) begin
      unique case (reg_addr)
        `ADSC_ADDR_CONV_CFG:  s_nxt.conv_cfg  = reg_wdata;
        `ADSC_ADDR_ALARM_CFG: s_nxt.alarm_cfg = reg_wdata;
        default:              ;
      endcase
    end

    // Register reads; update register is self clearing and reads zero
    if (reg_rd_en) begin
      unique case (reg_addr)
        `ADSC_ADDR_CONV_CFG:  s_nxt.rdata = s_r.conv_cfg;
        `ADSC_ADDR_ALARM_CFG: s_nxt.rdata = s_r.alarm_cfg;
        default:              s_nxt.rdata = 8'h00;
      endcase
    end

    // Results: direct mode shows each one at once, free-running waits for transfer
    if (conv_result_valid && conv_result_chan < 5'(`ADSC_NUM_CH)) begin
      s_nxt.latest[conv_result_chan] = conv_result_data;
      if (!conversion_mode_select) begin
        s_nxt.shown[conv_result_chan] = conv_result_data;
      end
    end
    if (update_xfer) begin
      s_nxt.shown = s_nxt.latest;
    end
    s_nxt.rd_data = (result_rd_chan < 5'(`ADSC_NUM_CH)) ? s_r.shown[result_rd_chan] : 12'h000;

    // Sequencer
    unique case (s_r.seq)
      SEQ_IDLE: begin
        if ((conv_trigger || conversion_mode_select) && any_enabled) begin
          s_nxt.seq    = SEQ_SAMPLE;
          s_nxt.active = 1'b1;
          s_nxt.chan   = first_hit[4:0];
          s_nxt.cnt    = reload(sample_time_select, first_hit[4:0]);
        end
      end
      SEQ_SAMPLE: begin
        if (s_r.cnt == 12'h000) begin
          s_nxt.done = 1'b1;
          if (next_hit[5]) begin
            s_nxt.chan = next_hit[4:0];
            s_nxt.cnt  = reload(sample_time_select, next_hit[4:0]);
          end else if (conversion_mode_select && any_enabled) begin
            s_nxt.chan = first_hit[4:0];
            s_nxt.cnt  = reload(sample_time_select, first_hit[4:0]);
          end else begin
            s_nxt.seq    = SEQ_IDLE;
            s_nxt.active = 1'b0;
          end
        end else begin
          s_nxt.cnt = s_r.cnt - 12'h001;
        end
      end
    endcase
  end

  // State register; reserved bits come up zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_r           <= '0;
      s_r.seq       <= SEQ_IDLE;
      s_r.conv_cfg  <= `ADSC_CONV_CFG_RESET;
      s_r.alarm_cfg <= `ADSC_ALARM_CFG_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata_r               = s_r.rdata;
  assign mux_select_r              = s_r.chan;
  assign sample_active_r           = s_r.active;
  assign sample_done_r             = s_r.done;
  assign reference_buffer_enable_r = s_r.conv_cfg[`ADSC_REFBUF_BIT];
  assign result_rd_data_r          = s_r.rd_data;

  ////////////////////////////////////////////////////////////////////////////
  // One filter per channel; the last slot is the temperature sensor
  generate
    for (genvar g = 0; g < `ADSC_NUM_CH; g++) begin : g_filt
      logic [8:0] need;
      if (g == `ADSC_TEMP_CH) begin : g_temp
        assign need = adsc_temp_need(temperature_alarm_filter_count);
      end else begin : g_chan
        assign need = adsc_chan_need(channel_alarm_filter_count);
      end
      adsc_alarm_filter u_filt (
        .mclk         (mclk),
        .rst          (rst),
        .sample_valid (conv_result_valid && conv_result_chan == 5'(g)),
        .out_of_range (conv_result_out_of_range),
        .need         (need),
        .alarm_r      (alarm_qualified_r[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_direct_idle;
    @(posedge mclk) disable iff (rst)
      (s_r.seq == SEQ_IDLE && !conversion_mode_select && !conv_trigger) |=> s_r.seq == SEQ_IDLE;
  endproperty
  a_direct_idle: assert property (p_direct_idle) else $error("direct mode started untriggered");

  property p_direct_stop;
    @(posedge mclk) disable iff (rst)
      (s_r.seq == SEQ_SAMPLE && s_r.cnt == 12'h000 && !next_hit[5] && !conversion_mode_select)
        |=> (s_r.seq == SEQ_IDLE && sample_done_r);
  endproperty
  a_direct_stop: assert property (p_direct_stop) else $error("direct pass did not stop");

  property p_auto_run;
    @(posedge mclk) disable iff (rst)
      (s_r.seq == SEQ_IDLE && conversion_mode_select && any_enabled) |=> sample_active_r;
  endproperty
  a_auto_run: assert property (p_auto_run) else $error("free-running mode stayed idle");

  property p_auto_wrap;
    @(posedge mclk) disable iff (rst)
      (s_r.seq == SEQ_SAMPLE && s_r.cnt == 12'h000 && !next_hit[5] && conversion_mode_select && any_enabled)
        |=> (s_r.seq == SEQ_SAMPLE && s_r.chan == $past(first_hit[4:0]));
  endproperty
  a_auto_wrap: assert property (p_auto_wrap) else $error("no wrap to first channel");

  property p_auto_hold;
    @(posedge mclk) disable iff (rst)
      (conversion_mode_select && !update_xfer) |=> $stable(s_r.shown);
  endproperty
  a_auto_hold: assert property (p_auto_hold) else $error("results shown without transfer");

  property p_xfer;
    @(posedge mclk) disable iff (rst)
      (update_xfer && !conv_result_valid) |=> s_r.shown == $past(s_r.latest);
  endproperty
  a_xfer: assert property (p_xfer) else $error("transfer did not copy results");

  property p_window;
    @(posedge mclk) disable iff (rst)
      (s_r.seq == SEQ_IDLE ##1 s_r.seq == SEQ_SAMPLE)
        |-> s_r.cnt == adsc_sample_cycles($past(sample_time_select), BIPOLAR_MASK[s_r.chan]) - 12'h001;
  endproperty
  a_window: assert property (p_window) else $error("sample window length wrong");

  property p_refbuf;
    @(posedge mclk) disable iff (rst)
      (reg_wr_en && reg_addr == `ADSC_ADDR_CONV_CFG)
        |=> reference_buffer_enable_r == $past(reg_wdata[`ADSC_REFBUF_BIT]);
  endproperty
  a_refbuf: assert property (p_refbuf) else $error("reference buffer enable not written");

  property p_chan_filt;
    @(posedge mclk) disable iff (rst)
      (reg_wr_en && reg_addr == `ADSC_ADDR_ALARM_CFG)
        |=> channel_alarm_filter_count == $past(reg_wdata[`ADSC_CHF_HI:`ADSC_CHF_LO])
            && temperature_alarm_filter_count == $past(reg_wdata[`ADSC_TMF_HI:`ADSC_TMF_LO]);
  endproperty
  a_chan_filt: assert property (p_chan_filt) else $error("filter fields not written");

endmodule : adsc_top

// file: adsc_host_model.sv
// Purpose: Host side of the byte-wide register port
// Assumes: One-cycle strobes; a write lands at the strobe edge, read data one cycle later
// Notes:   Reserved bits are cleared on writes so stored reserved bits stay zero
`timescale 1ns/1ns

module adsc_host_model (
  input  wire logic       mclk,
  output logic            reg_wr_en,
  output logic            reg_rd_en,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata_r
);
  // Idle strobes from time zero
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One write; strobe, address and data held through the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr_en <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= (a == 8'h10) ? (d & 8'hF0) : ((a == 8'h11) ? (d & 8'hF8) : d);
    @(posedge mclk);
    reg_wr_en <= 1'b0;
  endtask : wr

  // One read; data taken once the registered answer has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_rd_en <= 1'b1;
    reg_addr  <= a;
    @(posedge mclk);
    reg_rd_en <= 1'b0;
    #1;
    d = reg_rdata_r;
  endtask : rd

  // Buffer must run before results are trusted
  task automatic power_up;
    wr(8'h10, 8'h10);
  endtask : power_up

  // Free-running results only move on this request
  task automatic xfer;
    wr(8'h0F, 8'h10);
  endtask : xfer
endmodule : adsc_host_model

// file: adsc_top_tb_top.sv
// Purpose: Self-checking bench for the sequencer and alarm filter configuration
// Assumes: Host model on the register port; bench plays the converter result side
// Notes:   Default bipolar mask: channel 0 bipolar, channel 16 unipolar
`timescale 1ns/1ns
`include "adsc_defs.svh"

module adsc_top_tb_top;
  localparam int UNI [4] = '{`ADSC_CYC(`ADSC_T_SAMPLE_0_NS), `ADSC_CYC(`ADSC_T_SAMPLE_1_NS),
                             `ADSC_CYC(`ADSC_T_SAMPLE_2_NS), `ADSC_CYC(`ADSC_T_SAMPLE_3_NS)};
  localparam int CHN [8] = '{1, 4, 8, 16, 32, 64, 128, 256};
  localparam int TMN [4] = '{1, 2, 4, 8};

  logic        mclk, rst, reg_wr_en, reg_rd_en, conv_trigger;
  logic        conv_result_valid, conv_result_out_of_range;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata_r;
  logic [21:0] chan_enable, alarm_qualified_r;
  logic [4:0]  mux_select_r, conv_result_chan, result_rd_chan;
  logic        sample_active_r, sample_done_r, reference_buffer_enable_r;
  logic [11:0] conv_result_data, result_rd_data_r;
  int          fails, cmp_count, n;

  adsc_top dut (.mclk(mclk), .rst(rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .chan_enable(chan_enable),
    .conv_trigger(conv_trigger), .mux_select_r(mux_select_r), .sample_active_r(sample_active_r),
    .sample_done_r(sample_done_r), .reference_buffer_enable_r(reference_buffer_enable_r),
    .conv_result_valid(conv_result_valid), .conv_result_chan(conv_result_chan),
    .conv_result_data(conv_result_data), .conv_result_out_of_range(conv_result_out_of_range),
    .result_rd_chan(result_rd_chan), .result_rd_data_r(result_rd_data_r),
    .alarm_qualified_r(alarm_qualified_r));

  adsc_host_model host (.mclk(mclk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r));

  // 50 MHz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    if (fails == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    chk(16'(d), 16'(exp), "register read");
  endtask : rchk

  // Bounded wait on a flag; a hang ends the run
  task automatic wait_flag(input bit done_flag, input logic lvl, output int cnt);
    cnt = 0;
    do begin
      @(posedge mclk);
      #1;
      cnt++;
    end while (((done_flag ? sample_done_r : sample_active_r) !== lvl) && cnt < 8000);
    if (cnt >= 8000) begin
      fails++;
      $display("[ERR] %0t sequencer wait ran out", $time);
      final_report();
    end
  endtask : wait_flag

  // One converter result, with a gap cycle so valid is never set twice in a step
  task automatic send(input logic [4:0] ch, input logic [11:0] d, input logic oor);
    @(posedge mclk);
    conv_result_valid        <= 1'b1;
    conv_result_chan         <= ch;
    conv_result_data         <= d;
    conv_result_out_of_range <= oor;
    @(posedge mclk);
    conv_result_valid <= 1'b0;
    #1;
  endtask : send

  // Direct single-channel pass: window length, then stop and stay idle
  task automatic one_pass(input logic [7:0] cfg, input logic [4:0] ch, input int exp);
    int cnt;
    host.wr(8'h10, cfg);
    @(posedge mclk);
    chan_enable  <= 22'(1) << ch;
    conv_trigger <= 1'b1;
    @(posedge mclk);
    conv_trigger <= 1'b0;
    #1;
    chk(16'(mux_select_r), 16'(ch), "first channel");
    wait_flag(1'b1, 1'b1, cnt);
    chk(16'(cnt), 16'(exp), "sample window");
    chk(16'(sample_active_r), 16'h0000, "stop after pass");
    repeat (10) @(posedge mclk);
    #1;
    chk(16'(sample_active_r), 16'h0000, "idle without trigger");
  endtask : one_pass

  // Broken run, full run, then clear on an in-range sample
  task automatic alarm_run(input logic [4:0] ch, input int need);
    repeat (need - 1) send(ch, 12'h000, 1'b1);
    send(ch, 12'h000, 1'b0);
    repeat (need - 1) send(ch, 12'h000, 1'b1);
    chk(16'(alarm_qualified_r[ch]), 16'h0000, "alarm early");
    send(ch, 12'h000, 1'b1);
    chk(16'(alarm_qualified_r[ch]), 16'h0001, "alarm at count");
    send(ch, 12'h000, 1'b0);
    chk(16'(alarm_qualified_r[ch]), 16'h0000, "alarm clear");
  endtask : alarm_run

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    fails = 0;
    cmp_count = 0;
    rst = 1'b1;
    chan_enable = 22'h000000;
    conv_trigger = 1'b0;
    conv_result_valid = 1'b0;
    conv_result_chan = 5'h00;
    conv_result_data = 12'h000;
    conv_result_out_of_range = 1'b0;
    result_rd_chan = 5'h00;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    rchk(8'h10, 8'h00);
    rchk(8'h11, 8'h70);
    rchk(8'h0F, 8'h00);
    host.wr(8'h20, 8'hFF);
    rchk(8'h20, 8'h00);
    chk(16'(reference_buffer_enable_r), 16'h0000, "buffer off at reset");
    host.power_up();
    #1;
    chk(16'(reference_buffer_enable_r), 16'h0001, "buffer on");
    rchk(8'h10, 8'h10);
    for (int c = 0; c < 4; c++) begin
      one_pass({1'b0, 2'(c), 5'h10}, 5'd16, UNI[c]);
      one_pass({1'b0, 2'(c), 5'h10}, 5'd0, (c == 3) ? UNI[3] : UNI[2]);
    end
    // Free-running over channels 0 and 1, wrapping to 0
    chan_enable <= 22'h000003;
    host.wr(8'h10, 8'h90);
    wait_flag(1'b0, 1'b1, n);
    chk(16'(mux_select_r), 16'h0000, "auto first");
    wait_flag(1'b1, 1'b1, n);
    chk(16'(mux_select_r), 16'h0001, "auto second");
    wait_flag(1'b1, 1'b1, n);
    chk(16'(mux_select_r), 16'h0000, "auto wrap");
    chk(16'(sample_active_r), 16'h0001, "auto keeps going");
    @(posedge mclk);
    chan_enable <= 22'h000000;
    wait_flag(1'b0, 1'b0, n);
    // Results held back in free-running mode until a transfer
    @(posedge mclk);
    result_rd_chan <= 5'd3;
    send(5'd3, 12'hABC, 1'b0);
    repeat (3) @(posedge mclk);
    #1;
    chk(16'(result_rd_data_r), 16'h0000, "no copy in auto");
    host.xfer();
    repeat (3) @(posedge mclk);
    #1;
    chk(16'(result_rd_data_r), 16'h0ABC, "copy on transfer");
    host.wr(8'h10, 8'h10);
    result_rd_chan <= 5'd4;
    send(5'd4, 12'h123, 1'b0);
    repeat (3) @(posedge mclk);
    #1;
    chk(16'(result_rd_data_r), 16'h0123, "direct copy");
    // Direct pass over two unipolar channels: both in order, then stop
    @(posedge mclk);
    chan_enable  <= 22'h030000;
    conv_trigger <= 1'b1;
    @(posedge mclk);
    conv_trigger <= 1'b0;
    #1;
    chk(16'(mux_select_r), 16'h0010, "direct first of two");
    wait_flag(1'b1, 1'b1, n);
    chk(16'(mux_select_r), 16'h0011, "direct second of two");
    chk(16'(sample_active_r), 16'h0001, "direct pass continues");
    wait_flag(1'b1, 1'b1, n);
    chk(16'(n), 16'(UNI[0]), "second channel window");
    chk(16'(sample_active_r), 16'h0000, "direct pass stops");
    for (int c = 0; c < 8; c++) begin
      host.wr(8'h11, {3'(c), 2'b10, 3'b000});
      alarm_run(5'd5, CHN[c]);
    end
    for (int c = 0; c < 4; c++) begin
      host.wr(8'h11, {3'b011, 2'(c), 3'b000});
      alarm_run(5'd21, TMN[c]);
    end
    rchk(8'h11, 8'h78);
    // Second reset in mid-run restores both registers
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rchk(8'h11, 8'h70);
    rchk(8'h10, 8'h00);
    chk(16'(reference_buffer_enable_r), 16'h0000, "buffer off after reset");
    // Buffer must be switched on again after every power-up
    host.power_up();
    #1;
    chk(16'(reference_buffer_enable_r), 16'h0001, "buffer on after reset");
    final_report();
  end
endmodule : adsc_top_tb_top
